// >>> hw/img_asm_cfg.svh
// Constants of the safety process image assembler
`ifndef IMG_ASM_CFG_SVH
`define IMG_ASM_CFG_SVH
`define MAX_UNITS 18
`define NS_BYTES 64
`define UNIT_NS_BASE 2'h2
`define UNIT_NS_MAX 3
`define UNIT_SAFE_MAX 4
`define SAFE_BITS 96
`define SAFE_DATA_BITS 64
`define INT_BITS 32
`define MIRROR_BASE 56
`define KEY_LAST 11'h7FF
`define REV_CURRENT 12'h261
`define REV_LEGACY 12'h240
`define SEL_BLK_4 2'h1
`define SEL_BLK_8 2'h2
`define BLK_2 4'h2
`define BLK_4 4'h4
`define BLK_8 4'h8
`endif

// >>> hw/img_asm_pkg.sv
// Types of the safety process image assembler
`include "img_asm_cfg.svh"
package img_asm_pkg;
  typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_SCAN = 2'b01, PH_RUN = 2'b11} phase_t;
  typedef struct packed {
    logic present;
    logic lineTwo;
    logic [4:0] pos;
    logic isSub;
    logic [3:0] slot;
    logic extended;
    logic [2:0] safeBits;
  } unit_desc_t;
  typedef logic [`UNIT_NS_MAX-1:0][7:0] unit_bytes_t;
  typedef struct packed {
    phase_t phase;
    logic [10:0] key;
    logic [6:0] nsNext;
    logic [6:0] sfNext;
    logic [`MAX_UNITS-1:0] placed;
    logic [`MAX_UNITS-1:0][5:0] nsOff;
    logic [`MAX_UNITS-1:0][6:0] sfOff;
    logic [`MAX_UNITS-1:0][1:0] nsLen;
    logic [`MAX_UNITS-1:0][2:0] sfLen;
    logic [3:0] blk;
    logic [11:0] rev;
    logic [`NS_BYTES-1:0][7:0] inNs;
    logic [`SAFE_BITS-1:0] inSafe;
    logic [`MAX_UNITS-1:0] [`UNIT_NS_MAX-1:0][7:0] unitOutNs;
    logic [`MAX_UNITS-1:0][`UNIT_SAFE_MAX-1:0] unitOutSafe;
    logic [`INT_BITS-1:0] protoOut;
  } state_t;
endpackage

// >>> hw/safety_process_image_assembler.sv
// Safety process image assembler: layout discovery and cyclic image build
`timescale 1ns/1ns
`default_nettype none
`include "img_asm_cfg.svh"
module safety_process_image_assembler
  import img_asm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic teachIn,
  input wire logic legacySel,
  input wire logic [1:0] safeSizeSel,
  input wire unit_desc_t [`MAX_UNITS-1:0] units,
  input wire unit_bytes_t [`MAX_UNITS-1:0] unitIn,
  input wire logic [`MAX_UNITS-1:0][`UNIT_SAFE_MAX-1:0] unitSafeIn,
  input wire logic [`INT_BITS-1:0] protoIn,
  input wire logic [`NS_BYTES-1:0][7:0] outNs,
  input wire logic [`SAFE_BITS-1:0] outSafe,
  output logic [`NS_BYTES-1:0][7:0] inNs,
  output logic [`SAFE_BITS-1:0] inSafe,
  output logic [`MAX_UNITS-1:0][`UNIT_NS_MAX-1:0][7:0] unitOutNs,
  output logic [`MAX_UNITS-1:0][`UNIT_SAFE_MAX-1:0] unitOutSafe,
  output logic [`INT_BITS-1:0] protoOut,
  output logic [11:0] protoRev,
  output logic layoutReady
);

  state_t st;
  state_t next_st;
  logic found;
  logic [`SAFE_DATA_BITS-1:0] sfData;
  logic [1:0] len;
  int idx;

  // Block size in bytes from the configured selection
  function automatic logic [3:0] blockBytes(input logic [1:0] sel);
    if (sel == `SEL_BLK_4)
      return `BLK_4;
    else if (sel == `SEL_BLK_8)
      return `BLK_8;
    else
      return `BLK_2;
  endfunction

  // Order key: line, chain position, host before sub units, slot
  function automatic logic [10:0] unitKey(input unit_desc_t d);
    return {d.lineTwo, d.pos, d.isSub, d.slot};
  endfunction

  function automatic logic [2:0] safeCount(input unit_desc_t d);
    return (d.safeBits > 3'h4) ? 3'h4 : d.safeBits;
  endfunction

  function automatic logic [`SAFE_BITS-1:0] dataMask(input logic [3:0] b);
    logic [`SAFE_BITS-1:0] m;
    m = '0;
    for (int i = 0; i < `SAFE_DATA_BITS; i++)
    begin
      if (i < int'(b) * 8)
        m[i] = 1'b1;
    end
    return m;
  endfunction

  always_comb
  begin
    next_st = st;
    found = 1'b0;
    sfData = '0;
    len = 2'h0;
    idx = 0;
    unique case (st.phase)
      PH_IDLE:
      begin
        next_st.blk = blockBytes(safeSizeSel);
        next_st.rev = legacySel ? `REV_LEGACY : `REV_CURRENT;
        next_st.key = '0;
        next_st.nsNext = '0;
        next_st.sfNext = '0;
        next_st.placed = '0;
        next_st.phase = PH_SCAN;
      end
      PH_SCAN:
      begin
        // One key per cycle in ascending order fixes the image order
        for (int u = 0; u < `MAX_UNITS; u++)
        begin
          if (!found && units[u].present && unitKey(units[u]) == st.key)
          begin
            found = 1'b1;
            len = `UNIT_NS_BASE + {1'b0, units[u].extended};
            next_st.placed[u] = 1'b1;
            next_st.nsOff[u] = st.nsNext[5:0];
            next_st.sfOff[u] = st.sfNext;
            next_st.nsLen[u] = len;
            next_st.sfLen[u] = safeCount(units[u]);
            next_st.nsNext = st.nsNext + {5'h00, len};
            next_st.sfNext = st.sfNext + {4'h0, safeCount(units[u])};
          end
        end
        if (st.key == `KEY_LAST)
          next_st.phase = PH_RUN;
        else
          next_st.key = st.key + 11'h001;
      end
      PH_RUN:
      begin
      end
    endcase

    next_st.inNs = '0;
    next_st.inSafe = '0;
    next_st.unitOutNs = '0;
    next_st.unitOutSafe = '0;
    next_st.protoOut = '0;
    if (st.phase == PH_RUN)
    begin
      for (int u = 0; u < `MAX_UNITS; u++)
      begin
        for (int j = 0; j < `UNIT_NS_MAX; j++)
        begin
          if (st.placed[u] && j < int'(st.nsLen[u]))
          begin
            // Byte 0 holds error and diagnostic status in, acknowledges out
            next_st.inNs[int'(st.nsOff[u]) + j] = unitIn[u][j];
            next_st.unitOutNs[u][j] = outNs[int'(st.nsOff[u]) + j];
          end
        end
        for (int k = 0; k < `UNIT_SAFE_MAX; k++)
        begin
          idx = int'(st.sfOff[u]) + k;
          if (st.placed[u] && k < int'(st.sfLen[u]) && idx < int'(st.blk) * 8)
          begin
            sfData[idx] = unitSafeIn[u][k];
            next_st.unitOutSafe[u][k] = outSafe[idx] & ~teachIn;
          end
        end
      end
      if (teachIn)
        sfData = '0;
      for (int b = 0; b < `SAFE_DATA_BITS; b++)
      begin
        if (b < int'(st.blk) * 8)
          next_st.inSafe[b] = sfData[b];
      end
      for (int b = 0; b < `INT_BITS; b++)
      begin
        next_st.inSafe[int'(st.blk) * 8 + b] = protoIn[b];
        next_st.protoOut[b] = outSafe[int'(st.blk) * 8 + b];
      end
      for (int i = 0; i < 8; i++)
        next_st.inNs[`MIRROR_BASE + i] = sfData[i * 8 +: 8];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else if (clkEn)
      st <= next_st;
  end

  assign inNs = st.inNs;
  assign inSafe = st.inSafe;
  assign unitOutNs = st.unitOutNs;
  assign unitOutSafe = st.unitOutSafe;
  assign protoOut = st.protoOut;
  assign protoRev = st.rev;
  // Run is the only phase code with the upper bit set
  assign layoutReady = st.phase[1];

  // Helper sum and order check over the placed units
  function automatic int nsSum(input state_t s);
    int t;
    t = 0;
    for (int u = 0; u < `MAX_UNITS; u++)
      if (s.placed[u])
        t += int'(s.nsLen[u]);
    return t;
  endfunction

  function automatic logic orderOk(input state_t s, input unit_desc_t [`MAX_UNITS-1:0] d);
    logic ok;
    ok = 1'b1;
    for (int a = 0; a < `MAX_UNITS; a++)
      for (int b = 0; b < `MAX_UNITS; b++)
        if (s.placed[a] && s.placed[b] && unitKey(d[a]) < unitKey(d[b]) &&
            s.nsOff[a] >= s.nsOff[b])
          ok = 1'b0;
    return ok;
  endfunction

  AST_TEACH_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && teachIn) |=> ((inSafe & dataMask(st.blk)) == '0 && unitOutSafe == '0))
    else $error("Safe bits set during teach-in");
  AST_INT_APPEND: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && layoutReady) |=> inSafe[int'(st.blk) * 8 +: `INT_BITS] == $past(protoIn))
    else $error("Internal bytes not appended after safe block");
  AST_MIRROR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(layoutReady) ##1 layoutReady |-> inNs[`MIRROR_BASE +: 8] == inSafe[`SAFE_DATA_BITS-1:0]
      || st.blk != `BLK_8)
    else $error("Safe bits not mirrored");
  AST_ORDER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    layoutReady |-> orderOk(st, units))
    else $error("Image order broken");
  AST_BYTE_TOTAL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    layoutReady |-> int'(st.nsNext) == nsSum(st))
    else $error("Byte layout total wrong");
  AST_BIT_PACK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    layoutReady |-> !(st.placed[1] && st.placed[0] && unitKey(units[0]) < unitKey(units[1])
      && st.sfLen[0] != 3'h0) || st.sfOff[1] >= st.sfOff[0] + {4'h0, st.sfLen[0]})
    else $error("Safe bits overlap");
  AST_UNUSED_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    layoutReady |-> (inSafe & dataMask(st.blk) & ~dataMask(4'h0)) >> int'(st.sfNext) == '0
      || int'(st.sfNext) >= `SAFE_DATA_BITS)
    else $error("Unused safe bits not zero");
  AST_REVISION: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && st.phase == PH_IDLE) |=> protoRev == ($past(legacySel) ? `REV_LEGACY : `REV_CURRENT))
    else $error("Protocol revision wrong");
  AST_BLOCK_SIZE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    layoutReady |-> (st.blk == `BLK_2 || st.blk == `BLK_4 || st.blk == `BLK_8))
    else $error("Illegal safe block size");

  COV_RUN: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(layoutReady));
  COV_TEACH: cover property (@(posedge sys_clk) disable iff (!rst_n) layoutReady && teachIn);
  COV_LEGACY: cover property (@(posedge sys_clk) disable iff (!rst_n)
    layoutReady && protoRev == `REV_LEGACY);
  COV_LINE_TWO: cover property (@(posedge sys_clk) disable iff (!rst_n)
    layoutReady && st.placed[1] && units[1].lineTwo);

endmodule
`default_nettype wire

// >>> testbench/plc_model.sv
// Controller model: writes random non-safe and safe output images
`timescale 1ns/1ns
`default_nettype none
`include "img_asm_cfg.svh"
module plc_model (
  input wire logic sys_clk,
  input wire logic run,
  output logic [`NS_BYTES-1:0][7:0] outNs,
  output logic [`SAFE_BITS-1:0] outSafe
);
  always @(negedge sys_clk)
    if (run)
    begin
      for (int i = 0; i < `NS_BYTES; i++)
        outNs[i] <= 8'($urandom);
      outSafe <= {$urandom, $urandom, $urandom};
    end
    else
    begin
      outNs <= '0;
      outSafe <= '0;
    end
endmodule
`default_nettype wire

// >>> testbench/test_safety_process_image_assembler.sv
// Testbench: layout, packing, mirror and teach-in of the image assembler
`timescale 1ns/1ns
`default_nettype none
`include "img_asm_cfg.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module test_safety_process_image_assembler;
  import img_asm_pkg::*;
  typedef struct packed {
    logic [`SAFE_BITS-1:0] inSafe;
    logic [`NS_BYTES-1:0][7:0] inNs;
    logic [`MAX_UNITS-1:0][`UNIT_NS_MAX-1:0][7:0] unitOutNs;
    logic [`MAX_UNITS-1:0][`UNIT_SAFE_MAX-1:0] unitOutSafe;
    logic [`INT_BITS-1:0] protoOut;
  } exp_t;
  logic sys_clk = 0, rst_n = 0, clkEn = 1, teachIn = 0, legacySel = 0, layoutReady;
  logic [1:0] safeSizeSel = '0;
  unit_desc_t [`MAX_UNITS-1:0] units = '0;
  unit_bytes_t [`MAX_UNITS-1:0] unitIn = '0;
  logic [`MAX_UNITS-1:0][`UNIT_SAFE_MAX-1:0] unitSafeIn = '0, unitOutSafe;
  logic [`INT_BITS-1:0] protoIn = '0, protoOut;
  logic [`NS_BYTES-1:0][7:0] outNs, inNs;
  logic [`SAFE_BITS-1:0] outSafe, inSafe;
  logic [`MAX_UNITS-1:0][`UNIT_NS_MAX-1:0][7:0] unitOutNs;
  logic [11:0] protoRev;
  int errors = 0, comparisons = 0, cycles = 0, blk, cnt;
  int ord[5] = '{0, 2, 4, 3, 1};
  exp_t q[$];
  exp_t m;
  safety_process_image_assembler dut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .teachIn(teachIn), .legacySel(legacySel), .safeSizeSel(safeSizeSel), .units(units),
    .unitIn(unitIn), .unitSafeIn(unitSafeIn), .protoIn(protoIn), .outNs(outNs),
    .outSafe(outSafe), .inNs(inNs), .inSafe(inSafe), .unitOutNs(unitOutNs),
    .unitOutSafe(unitOutSafe), .protoOut(protoOut), .protoRev(protoRev),
    .layoutReady(layoutReady));
  plc_model plc (.sys_clk(sys_clk), .run(layoutReady), .outNs(outNs), .outSafe(outSafe));
  initial forever #25 sys_clk = ~sys_clk;
  task automatic end_sim;
    $display("counts: comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      errors++;
      end_sim();
    end
  end
  // Drive one cycle of traffic and note the expected image
  task automatic step(input logic teach);
    exp_t e;
    int n, s, x;
    @(negedge sys_clk);
    #1;
    teachIn = teach;
    for (int i = 0; i < `MAX_UNITS; i++)
    begin
      unitIn[i] = 24'($urandom);
      unitSafeIn[i] = 4'($urandom);
    end
    protoIn = $urandom;
    e = '0;
    n = 0;
    s = 0;
    e.protoOut = outSafe[blk*8 +: 32];
    e.inSafe[blk*8 +: 32] = protoIn;
    foreach (ord[j])
    begin
      x = ord[j];
      for (int b = 0; b < 2 + units[x].extended; b++)
      begin
        e.inNs[n] = unitIn[x][b];
        e.unitOutNs[x][b] = outNs[n];
        n++;
      end
      for (int k = 0; k < units[x].safeBits; k++)
      begin
        e.inSafe[s] = !teach & unitSafeIn[x][k];
        e.unitOutSafe[x][k] = !teach & outSafe[s];
        s++;
      end
    end
    e.inNs[63:56] = e.inSafe[63:0] & ~(64'hFFFFFFFFFFFFFFFF << (blk * 8));
    q.push_back(e);
  endtask
  always @(posedge sys_clk)
  begin
    #1;
    if (q.size() > 0)
    begin
      m = q.pop_front();
      `CHK(inSafe, m.inSafe)
      `CHK(inNs[10:0], m.inNs[10:0])
      `CHK(unitOutNs, m.unitOutNs)
      `CHK(unitOutSafe, m.unitOutSafe)
      `CHK(protoOut, m.protoOut)
      `CHK(inNs, m.inNs)
    end
  end
  task automatic run_cfg(input logic [1:0] sel, input logic leg);
    rst_n = 0;
    safeSizeSel = sel;
    legacySel = leg;
    blk = (sel == 2'h1) ? 4 : (sel == 2'h2) ? 8 : 2;
    repeat (12) @(negedge sys_clk);
    rst_n = 1;
    cnt = 0;
    @(posedge sys_clk);
    #1;
    `CHK(inSafe, 96'h0)
    // Freeze discovery for five edges; the edge count must stretch by five
    @(negedge sys_clk);
    clkEn = 1'b0;
    repeat (5) @(negedge sys_clk);
    clkEn = 1'b1;
    cnt = 6;
    while (layoutReady !== 1'b1 && cnt < 3000)
    begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end
    `CHK(cnt, 2054)
    `CHK(protoRev, leg ? `REV_LEGACY : `REV_CURRENT)
    repeat (20) step(1'b0);
    repeat (4) step(1'b1);
    step(1'b0);
    repeat (2) @(negedge sys_clk);
    $display("test done: size select %0d legacy %0d", sel, leg);
  endtask
  initial
  begin
    units[0] = '{1'b1, 1'b0, 5'h00, 1'b0, 4'h0, 1'b0, 3'h1};
    units[1] = '{1'b1, 1'b1, 5'h01, 1'b0, 4'h0, 1'b0, 3'h2};
    units[2] = '{1'b1, 1'b0, 5'h01, 1'b0, 4'h0, 1'b1, 3'h2};
    units[3] = '{1'b1, 1'b0, 5'h01, 1'b1, 4'h2, 1'b0, 3'h1};
    units[4] = '{1'b1, 1'b0, 5'h01, 1'b1, 4'h1, 1'b0, 3'h3};
    void'($urandom(83));
    for (int c = 0; c < 4; c++)
      run_cfg(2'(c), c[0]);
    end_sim();
  end
endmodule
`default_nettype wire
